// File: sarseq_pkg.sv
`default_nettype none
package sarseq_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] SARSEQ_OFF_CTRL = 8'h00;
  localparam logic [7:0] SARSEQ_OFF_CFG = 8'h04;
  localparam logic [7:0] SARSEQ_OFF_CLKDIV = 8'h08;
  localparam logic [7:0] SARSEQ_OFF_STATUS = 8'h0c;
  localparam logic [7:0] SARSEQ_OFF_RESULT = 8'h10;
  localparam logic [7:0] SARSEQ_OFF_RESULT2 = 8'h14;

  // ----------------------------------------------------------------
  // field positions and limits
  // ----------------------------------------------------------------
  localparam int SARSEQ_RES_W = 12;
  localparam int SARSEQ_CFG_BITS_LSB = 0;
  localparam int SARSEQ_CFG_SAMP_LSB = 4;
  localparam int SARSEQ_CFG_REF_LSB = 8;
  localparam int SARSEQ_CFG_DIFF_BIT = 10;
  localparam int SARSEQ_CFG_INSEL_BIT = 11;
  localparam int SARSEQ_CLK_DIV_LSB = 0;
  localparam int SARSEQ_CLK_SRC_BIT = 8;
  localparam logic [3:0] SARSEQ_MIN_BITS = 4'h1;
  localparam logic [3:0] SARSEQ_MAX_BITS = 4'hc;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [3:0] SARSEQ_RST_BITS = 4'hc;
  localparam logic [3:0] SARSEQ_RST_SAMP = 4'h2;
  localparam logic [1:0] SARSEQ_RST_REF = 2'h0;
  localparam logic [7:0] SARSEQ_RST_DIV = 8'h00;
  localparam logic [11:0] SARSEQ_RST_RESULT = 12'hfff;

  // reference choices; code 0 is the analog supply rail
  typedef enum logic [1:0] {
    SARSEQ_REF_ANALOG_SUPPLY = 2'h0,
    SARSEQ_REF_BANDGAP = 2'h1,
    SARSEQ_REF_EXTERNAL = 2'h2
  } sarseq_ref_t;

  typedef struct packed {
    logic [3:0] conv_bits;
    logic [3:0] samp_cycles;
    logic [1:0] ref_sel;
    logic diff_mode;
    logic input_test;
    logic [7:0] clk_div;
    logic clk_src;
  } sarseq_cfg_t;

  typedef struct packed {
    logic [11:0] data;
    logic valid;
  } sarseq_res_t;

endpackage : sarseq_pkg
`default_nettype wire

// File: sarseq_clkdiv.sv
`timescale 1ns/100ps
`default_nettype none
module sarseq_clkdiv
  import sarseq_pkg::*;
#(
  parameter int DIV_W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic src_sel,
  input wire logic alt_tick,
  input wire logic [DIV_W-1:0] div,
  output logic tick
);

  if (DIV_W < 1 || DIV_W > 16) begin : g_bad_div
    $error("sarseq_clkdiv: DIV_W out of range");
  end

  typedef struct packed {
    logic [DIV_W-1:0] cnt;
    logic tick;
  } sarseq_div_st_t;

  sarseq_div_st_t s_q, s_d;
  logic src_ev;

  // converter clock as an enable: one tick per (div+1) source events
  always_comb begin
    s_d = s_q;
    src_ev = src_sel ? alt_tick : 1'b1;
    s_d.tick = 1'b0;
    if (src_ev) begin
      if (s_q.cnt >= div) begin
        s_d.cnt = '0;
        s_d.tick = 1'b1;
      end else begin
        s_d.cnt = s_q.cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tick = s_q.tick;

endmodule : sarseq_clkdiv
`default_nettype wire

// File: sarseq_top.sv
// Added by the designer: the APB register port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module sarseq_top
  import sarseq_pkg::*;
#(
  parameter int DIV_W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic alt_clk_tick,
  input wire logic comp_in,
  output logic conv_sample,
  output logic conv_trial,
  output logic [11:0] conv_dac,
  output logic conv_diff,
  output logic [1:0] conv_ref_sel,
  output logic conv_input_test,
  output logic [11:0] sensing_dsp_data,
  output logic sensing_dsp_valid,
  output logic conv_done
);

  if (DIV_W != 8) begin : g_bad_div
    $error("sarseq_top: DIV_W must match the divider field");
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SQ_IDLE,
    SQ_SAMPLE,
    SQ_CONVERT,
    SQ_FINISH
  } sarseq_fsm_t;

  typedef struct packed {
    sarseq_fsm_t fsm;
    sarseq_cfg_t cfg;
    sarseq_cfg_t run;
    logic cont;
    logic start_req;
    logic [4:0] cnt;
    logic [3:0] bit_idx;
    logic [11:0] sar;
    logic [11:0] result;
    logic [11:0] result2;
    logic busy;
    logic done;
    logic dsp_valid;
    logic sample;
    logic trial;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } sarseq_st_t;

  sarseq_st_t s_q, s_d;
  logic conv_tick;
  logic wr_acc, rd_acc;
  logic start_wr;

  // formatted value: top n bits kept, lower bits forced high
  function automatic logic [11:0] sarseq_fmt(input logic [11:0] v, input logic [3:0] n);
    logic [11:0] m;
    m = 12'hfff >> n;
    return v | m;
  endfunction : sarseq_fmt

  function automatic logic [3:0] sarseq_clip_bits(input logic [3:0] n);
    logic [3:0] r;
    r = n;
    if (n < SARSEQ_MIN_BITS) r = SARSEQ_MIN_BITS;
    if (n > SARSEQ_MAX_BITS) r = SARSEQ_MAX_BITS;
    return r;
  endfunction : sarseq_clip_bits

  sarseq_clkdiv #(.DIV_W(DIV_W)) u_div (
    .pclk(pclk),
    .presetn(presetn),
    .src_sel(s_q.run.clk_src),
    .alt_tick(alt_clk_tick),
    .div(s_q.run.clk_div),
    .tick(conv_tick)
  );

  assign wr_acc = psel && penable && pwrite && s_q.pready;
  assign rd_acc = psel && !penable && !pwrite;
  assign start_wr = wr_acc && !s_q.pslverr && (paddr == SARSEQ_OFF_CTRL) && pwdata[0];

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    s_d.dsp_valid = 1'b0;
    // no wait states: ready in the first access-phase cycle
    s_d.pready = psel && !penable;
    s_d.pslverr = 1'b0;
    if (psel && !penable) begin
      s_d.prdata = '0;
      case (paddr)
        SARSEQ_OFF_CTRL, SARSEQ_OFF_CFG, SARSEQ_OFF_CLKDIV, SARSEQ_OFF_STATUS: ;
        SARSEQ_OFF_RESULT, SARSEQ_OFF_RESULT2: ;
        default: s_d.pslverr = 1'b1;
      endcase
      if (rd_acc) begin
        case (paddr)
          SARSEQ_OFF_CTRL: s_d.prdata[1] = s_q.cont;
          SARSEQ_OFF_CFG: begin
            s_d.prdata[SARSEQ_CFG_BITS_LSB +: 4] = s_q.cfg.conv_bits;
            s_d.prdata[SARSEQ_CFG_SAMP_LSB +: 4] = s_q.cfg.samp_cycles;
            s_d.prdata[SARSEQ_CFG_REF_LSB +: 2] = s_q.cfg.ref_sel;
            s_d.prdata[SARSEQ_CFG_DIFF_BIT] = s_q.cfg.diff_mode;
            s_d.prdata[SARSEQ_CFG_INSEL_BIT] = s_q.cfg.input_test;
          end
          SARSEQ_OFF_CLKDIV: begin
            s_d.prdata[SARSEQ_CLK_DIV_LSB +: 8] = s_q.cfg.clk_div;
            s_d.prdata[SARSEQ_CLK_SRC_BIT] = s_q.cfg.clk_src;
          end
          SARSEQ_OFF_STATUS: s_d.prdata[0] = s_q.busy;
          SARSEQ_OFF_RESULT: s_d.prdata[11:0] = s_q.result;
          SARSEQ_OFF_RESULT2: s_d.prdata[11:0] = s_q.result2;
          default: s_d.prdata = '0;
        endcase
      end
    end
    if (wr_acc && !s_q.pslverr) begin
      case (paddr)
        SARSEQ_OFF_CTRL: begin
          s_d.start_req = s_q.start_req | pwdata[0];
          s_d.cont = pwdata[1];
        end
        SARSEQ_OFF_CFG: begin
          s_d.cfg.conv_bits = sarseq_clip_bits(pwdata[SARSEQ_CFG_BITS_LSB +: 4]);
          s_d.cfg.samp_cycles = pwdata[SARSEQ_CFG_SAMP_LSB +: 4];
          s_d.cfg.ref_sel = pwdata[SARSEQ_CFG_REF_LSB +: 2];
          s_d.cfg.diff_mode = pwdata[SARSEQ_CFG_DIFF_BIT];
          s_d.cfg.input_test = pwdata[SARSEQ_CFG_INSEL_BIT];
        end
        SARSEQ_OFF_CLKDIV: begin
          s_d.cfg.clk_div = pwdata[SARSEQ_CLK_DIV_LSB +: 8];
          s_d.cfg.clk_src = pwdata[SARSEQ_CLK_SRC_BIT];
        end
        default: ;
      endcase
    end
    // sequencer leaves SQ_IDLE without a tick; the other states advance on converter clock ticks only
    case (s_q.fsm)
      SQ_IDLE: begin
        // config snapshot so a write mid-conversion cannot skew timing
        s_d.run = s_d.cfg;
        if (s_q.start_req || s_q.cont) begin
          // a start written in this very cycle stays pending
          s_d.start_req = start_wr;
          s_d.busy = 1'b1;
          s_d.cnt = 5'h00;
          s_d.sar = 12'h000;
          s_d.fsm = SQ_SAMPLE;
        end
      end
      SQ_SAMPLE: if (conv_tick) begin
        if (s_q.cnt + 5'h01 >= {1'b0, s_q.run.samp_cycles}) begin
          s_d.bit_idx = 4'hb;
          s_d.cnt = 5'h00;
          s_d.sar = 12'h800;
          s_d.fsm = SQ_CONVERT;
        end else begin
          s_d.cnt = s_q.cnt + 5'h01;
        end
      end
      SQ_CONVERT: if (conv_tick) begin
        if (!comp_in) s_d.sar[s_q.bit_idx] = 1'b0;
        if (s_q.cnt + 5'h01 >= {1'b0, s_q.run.conv_bits}) begin
          s_d.fsm = SQ_FINISH;
        end else begin
          s_d.cnt = s_q.cnt + 5'h01;
          s_d.bit_idx = s_q.bit_idx - 4'h1;
          s_d.sar[s_q.bit_idx - 4'h1] = 1'b1;
        end
      end
      SQ_FINISH: if (conv_tick) begin
        // the extra converter clock of each conversion
        s_d.result2 = s_q.result;
        s_d.result = sarseq_fmt(s_q.sar, s_q.run.conv_bits);
        s_d.done = 1'b1;
        s_d.dsp_valid = 1'b1;
        s_d.busy = 1'b0;
        s_d.fsm = SQ_IDLE;
      end
      default: s_d.fsm = SQ_IDLE;
    endcase
    // phase outputs registered alongside the state
    s_d.sample = (s_d.fsm == SQ_SAMPLE);
    s_d.trial = (s_d.fsm == SQ_CONVERT);
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
      s_q.fsm <= SQ_IDLE;
      s_q.cfg.conv_bits <= SARSEQ_RST_BITS;
      s_q.cfg.samp_cycles <= SARSEQ_RST_SAMP;
      s_q.cfg.ref_sel <= SARSEQ_RST_REF;
      s_q.cfg.clk_div <= SARSEQ_RST_DIV;
      s_q.run.conv_bits <= SARSEQ_RST_BITS;
      s_q.run.samp_cycles <= SARSEQ_RST_SAMP;
      s_q.result <= SARSEQ_RST_RESULT;
      s_q.result2 <= SARSEQ_RST_RESULT;
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata = s_q.prdata;
  assign pready = s_q.pready;
  assign pslverr = s_q.pslverr;
  assign conv_sample = s_q.sample;
  assign conv_trial = s_q.trial;
  assign conv_dac = s_q.sar;
  assign conv_diff = s_q.run.diff_mode;
  assign conv_ref_sel = s_q.run.ref_sel;
  assign conv_input_test = s_q.run.input_test;
  assign sensing_dsp_data = s_q.result;
  assign sensing_dsp_valid = s_q.dsp_valid;
  assign conv_done = s_q.done;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_done_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    conv_done |=> !conv_done) else $error("done longer than one cycle");
  a_low_ones: assert property (@(posedge pclk) disable iff (!presetn)
    conv_done |-> ((sensing_dsp_data & (12'hfff >> s_q.run.conv_bits))
      == (12'hfff >> s_q.run.conv_bits))) else $error("low bits not one");
  a_dsp_pair: assert property (@(posedge pclk) disable iff (!presetn)
    conv_done == sensing_dsp_valid) else $error("dsp valid not with done");
  a_result_load: assert property (@(posedge pclk) disable iff (!presetn)
    (s_q.fsm == SQ_FINISH && conv_tick) |=> (conv_done && s_q.result2 == $past(s_q.result)))
    else $error("result not loaded");
  a_bits_range: assert property (@(posedge pclk) disable iff (!presetn)
    s_q.cfg.conv_bits >= SARSEQ_MIN_BITS && s_q.cfg.conv_bits <= SARSEQ_MAX_BITS)
    else $error("bits out of range");
  a_conv_len: assert property (@(posedge pclk) disable iff (!presetn)
    (conv_trial && conv_tick && s_q.cnt == 5'h00) |=> conv_trial || s_q.fsm == SQ_FINISH)
    else $error("convert phase left early");
  a_cfg_write: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_acc && paddr == SARSEQ_OFF_CFG && !pslverr) |=> s_q.cfg.diff_mode == $past(pwdata[10]))
    else $error("mode not written");
  a_mux_steady: assert property (@(posedge pclk) disable iff (!presetn)
    (s_q.fsm != SQ_IDLE) |=> $stable(conv_input_test) || s_q.fsm == SQ_IDLE)
    else $error("input changed mid conversion");
  c_done: cover property (@(posedge pclk) conv_done);
  c_diff: cover property (@(posedge pclk) conv_done && conv_diff);
  c_err: cover property (@(posedge pclk) pready && pslverr);

endmodule : sarseq_top
`default_nettype wire

// File: sarseq_conv_model.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------
// comparator of the converter core
// ----------------------------------------------------------------
module sarseq_conv_model
  import sarseq_pkg::*;
(
  input wire logic pclk,
  input wire logic conv_trial,
  input wire logic [11:0] conv_dac,
  input wire logic [11:0] level,
  output logic comp_in
);
  logic junk_q = 1'b0;

  // outside trials the answer means nothing, so keep it moving
  always @(posedge pclk) begin
    junk_q <= ~junk_q;
  end

  assign comp_in = conv_trial ? (conv_dac <= level) : junk_q;
endmodule : sarseq_conv_model
`default_nettype wire

// File: sar_adc_sequencer_tb.sv
`timescale 1ns/100ps
`default_nettype none
module sar_adc_sequencer_tb;
  import sarseq_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, alt_clk_tick, comp_in, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, conv_sample, conv_trial, conv_diff, conv_input_test;
  logic sensing_dsp_valid, conv_done;
  logic [11:0] conv_dac, sensing_dsp_data, level, prev;
  logic [1:0] conv_ref_sel;
  int n_mismatch = 0;
  int checked = 0;
  int cyc = 0;

  sarseq_top u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .alt_clk_tick, .comp_in, .conv_sample, .conv_trial,
    .conv_dac, .conv_diff, .conv_ref_sel, .conv_input_test, .sensing_dsp_data,
    .sensing_dsp_valid, .conv_done);

  sarseq_conv_model u_core (.pclk, .conv_trial, .conv_dac, .level, .comp_in);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic test_done;
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : test_done

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk({31'h0, pready}, 32'h1, "no pready");
  endtask : apb

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_defaults;
    apb(1'b0, SARSEQ_OFF_CFG, 32'h0);
    chk(rd, 32'h0000002c, "cfg reset");
    apb(1'b0, SARSEQ_OFF_CLKDIV, 32'h0);
    chk(rd, 32'h0, "clkdiv reset");
    apb(1'b0, SARSEQ_OFF_RESULT, 32'h0);
    chk(rd, 32'hfff, "result reset");
    apb(1'b0, SARSEQ_OFF_RESULT2, 32'h0);
    chk(rd, 32'hfff, "result2 reset");
    chk({20'h0, sensing_dsp_data}, 32'hfff, "dsp data reset");
    apb(1'b0, SARSEQ_OFF_CTRL, 32'h0);
    chk(rd, 32'h0, "ctrl reset");
    apb(1'b0, SARSEQ_OFF_STATUS, 32'h0);
    chk(rd, 32'h0, "status reset");
    apb(1'b0, 8'h20, 32'h0);
    chk({31'h0, er}, 32'h1, "unmapped error");
    chk(rd, 32'h0, "unmapped read");
  endtask : t_defaults

  task automatic t_conv(input logic [3:0] b, input logic [3:0] s, input logic [1:0] r,
      input logic df, input logic ti, input logic [7:0] dv, input logic sr,
      input logic [11:0] lv);
    int n, t, p;
    logic [11:0] e;
    // low bits of the level set, so the trial word's tail cannot matter
    e = lv | ((12'h001 << (12 - b)) - 12'h001);
    level <= e;
    p = (sr ? 2 : 1) * (dv + 1);
    t = (s + b + 1) * p;
    apb(1'b1, SARSEQ_OFF_CFG, {20'h0, ti, df, r, s, b});
    apb(1'b1, SARSEQ_OFF_CLKDIV, {23'h0, sr, dv});
    apb(1'b1, SARSEQ_OFF_CTRL, 32'h1);
    n = 0;
    while (conv_sample !== 1'b1 && n < 2000) begin
      @(posedge pclk);
      n++;
    end
    chk({30'h0, conv_ref_sel}, {30'h0, r}, "ref");
    chk({31'h0, conv_diff}, {31'h0, df}, "diff");
    chk({31'h0, conv_input_test}, {31'h0, ti}, "input");
    n = 0;
    while (conv_done !== 1'b1 && n < 2000) begin
      @(posedge pclk);
      n++;
    end
    chk({31'h0, n >= t - p + 1 && n <= t}, 32'h1, "duration");
    chk({31'h0, sensing_dsp_valid}, 32'h1, "dsp valid");
    chk({20'h0, sensing_dsp_data}, {20'h0, e}, "dsp data");
    apb(1'b0, SARSEQ_OFF_RESULT, 32'h0);
    chk(rd, {20'h0, e}, "result");
    chk({31'h0, er}, 32'h0, "result error");
    apb(1'b0, SARSEQ_OFF_RESULT2, 32'h0);
    chk(rd, {20'h0, prev}, "result2");
    prev = e;
  endtask : t_conv

  task automatic t_cont;
    int n, k;
    apb(1'b1, SARSEQ_OFF_CTRL, 32'h2);
    apb(1'b0, SARSEQ_OFF_CTRL, 32'h0);
    chk(rd, 32'h2, "cont readback");
    for (k = 0; k < 2; k++) begin
      n = 0;
      do begin
        @(posedge pclk);
        n++;
      end while (conv_done !== 1'b1 && n < 2000);
      chk({31'h0, conv_done}, 32'h1, "cont done");
      chk({20'h0, sensing_dsp_data}, {20'h0, level}, "cont data");
    end
    apb(1'b1, SARSEQ_OFF_CTRL, 32'h0);
    n = 0;
    do begin
      apb(1'b0, SARSEQ_OFF_STATUS, 32'h0);
      n++;
    end while (rd !== 32'h0 && n < 100);
    chk(rd, 32'h0, "busy cleared");
    repeat (2) @(posedge pclk);
    chk({31'h0, conv_sample}, 32'h0, "cont stopped");
  endtask : t_cont

  task automatic t_reset_mid;
    apb(1'b1, SARSEQ_OFF_CTRL, 32'h1);
    apb(1'b0, SARSEQ_OFF_STATUS, 32'h0);
    chk(rd, 32'h1, "busy while converting");
    @(posedge pclk);
    chk({31'h0, conv_sample}, 32'h1, "sample before reset");
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    chk({31'h0, conv_sample}, 32'h0, "sample in reset");
    presetn <= 1'b1;
    prev = 12'hfff;
    t_defaults();
  endtask : t_reset_mid

  // ----------------------------------------------------------------
  // clock, timeout, main sequence
  // ----------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    alt_clk_tick <= ~alt_clk_tick;
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      $display("ERROR %0t run hung", $time);
      test_done();
    end
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    alt_clk_tick = 1'b0;
    level = 12'h000;
    prev = 12'hfff;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_defaults();
    // divider 3 keeps a 12-bit rate within bounds
    t_conv(4'hc, 4'h2, 2'h0, 1'b0, 1'b0, 8'h03, 1'b0, 12'ha5a);
    t_conv(4'h7, 4'h1, 2'h1, 1'b1, 1'b1, 8'h02, 1'b0, 12'h3c0);
    t_conv(4'h1, 4'h4, 2'h2, 1'b0, 1'b1, 8'h00, 1'b1, 12'h800);
    t_conv(4'hc, 4'h3, 2'h0, 1'b1, 1'b0, 8'h01, 1'b1, 12'h001);
    t_cont();
    t_reset_mid();
    test_done();
  end
endmodule : sar_adc_sequencer_tb
`default_nettype wire
